// file: src/phan_autoneg.sv
// Purpose: Speed/duplex negotiation with parallel detect for a 10/100 PHY
// Assumes: Line-side inputs are clean one-cycle or level indications
// Notes:   APB slave, no wait states on any access
`timescale 1ns/100ps
`include "phan_defines.svh"

module phan_autoneg #(
	parameter int PERIOD_CYC = `PHAN_PERIOD_NS / `PHAN_CLK_NS,
	parameter int MISS_CYC   = `PHAN_MISS_NS / `PHAN_CLK_NS,
	parameter int BREAK_CYC  = `PHAN_BREAK_MS * 1000000 / `PHAN_CLK_NS
) (
	input  wire logic               ref_clk,
	input  wire logic               sys_rst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               flpPulseIn,
	input  wire logic               nlpIn,
	input  wire logic               sym100In,
	input  wire logic               sigDetect,
	input  wire logic               txActive,
	input  wire logic               rxActive,
	output logic                    flpPulseOut,
	output logic                    linkHold,
	output logic                    linkUp,
	output phan_pkg::phan_mode_t    linkMode,
	output logic                    crs,
	output logic                    col
);

	localparam int SLOT_CYC = `PHAN_SLOT_NS / `PHAN_CLK_NS;
	localparam int DATA_CYC = `PHAN_DATA_MAX_NS / `PHAN_CLK_NS;
	localparam int GAP_CYC  = `PHAN_GAP_NS / `PHAN_CLK_NS;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	function automatic logic [7:0] byteAddr(input logic [4:0] idx);
		byteAddr = {1'b0, idx, 2'b00};
	endfunction : byteAddr

	// Returns {valid, speed100, full}; priority order is fixed
	function automatic logic [2:0] resolve(input logic [15:0] a,
		input logic [15:0] b);
		logic [3:0] common;
		common = a[8:5] & b[8:5];
		if (common[3])
			resolve = 3'h7;
		else if (common[2])
			resolve = 3'h6;
		else if (common[1])
			resolve = 3'h5;
		else if (common[0])
			resolve = 3'h4;
		else
			resolve = 3'h0;
	endfunction : resolve

	function automatic logic [2:0] specCode(input phan_pkg::phan_mode_t m);
		case ({m.speed100, m.fullDuplex})
			2'b11:   specCode = `PHAN_SPEC_100FD;
			2'b10:   specCode = `PHAN_SPEC_100HD;
			2'b01:   specCode = `PHAN_SPEC_10FD;
			default: specCode = `PHAN_SPEC_10HD;
		endcase
	endfunction : specCode

	// ------------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------------
	phan_pkg::phan_state_t state_reg;
	logic [15:0] ctrl_reg;
	logic [15:0] adv_reg;
	logic [15:0] advLatch_reg;
	logic [15:0] lpa_reg;
	logic        lpAble_reg;
	logic        pdFault_reg;
	logic        anDone_reg;
	logic        pdownPrev_reg;
	logic [31:0] timer_reg;
	logic [2:0]  matchCnt_reg;
	logic [15:0] lastRx_reg;
	logic        rxSeen_reg;
	logic        nlpSeen_reg;
	logic        symSeen_reg;
	logic        anTrig;
	logic        apbWrite;
	logic        apbRead;
	logic [7:0]  addrHit;

	assign apbWrite = psel && penable && pready && pwrite;
	assign apbRead  = psel && penable && pready && !pwrite;
	assign addrHit  = paddr;

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (psel && !penable) begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			case (addrHit)
				byteAddr(`PHAN_IDX_CTRL): prdata[15:0] <= ctrl_reg;
				byteAddr(`PHAN_IDX_ADV):  prdata[15:0] <= adv_reg;
				byteAddr(`PHAN_IDX_LPA):  prdata[15:0] <= lpa_reg;
				byteAddr(`PHAN_IDX_EXP): begin
					prdata[`PHAN_EXP_LPANABLE] <= lpAble_reg;
					prdata[`PHAN_EXP_PDFAULT]  <= pdFault_reg;
				end
				byteAddr(`PHAN_IDX_SPEC): begin
					prdata[`PHAN_SPEC_DONE] <= anDone_reg;
					prdata[`PHAN_SPEC_IND_LO +: 3] <= specCode(linkMode);
				end
				default: pslverr <= 1'b1;
			endcase
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Control register; restart and soft reset bits clear themselves
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ctrl_reg <= `PHAN_CTRL_RST;
			adv_reg  <= `PHAN_ADV_RST;
		end else if (ctrl_reg[`PHAN_CTRL_SRST]) begin
			ctrl_reg <= `PHAN_CTRL_RST;
			adv_reg  <= `PHAN_ADV_RST;
		end else begin
			if (state_reg == phan_pkg::ST_BREAK)
				ctrl_reg[`PHAN_CTRL_RESTART] <= 1'b0;
			if (!ctrl_reg[`PHAN_CTRL_ANEN])
				ctrl_reg[`PHAN_CTRL_RESTART] <= 1'b0;
			if (apbWrite && addrHit == byteAddr(`PHAN_IDX_CTRL))
				ctrl_reg <= pwdata[15:0];
			// Selector is fixed; only abilities are writable
			if (apbWrite && addrHit == byteAddr(`PHAN_IDX_ADV))
				adv_reg[8:5] <= pwdata[8:5];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			pdownPrev_reg <= 1'b0;
		else
			pdownPrev_reg <= ctrl_reg[`PHAN_CTRL_PDOWN];
	end

	// Soft reset or leaving power-down restarts the session
	assign anTrig = ctrl_reg[`PHAN_CTRL_SRST] ||
		(pdownPrev_reg && !ctrl_reg[`PHAN_CTRL_PDOWN]);

	// ------------------------------------------------------------------
	// Burst transmitter
	// ------------------------------------------------------------------
	logic [31:0] period_reg;
	logic [10:0] slotCnt_reg;
	logic [5:0]  slot_reg;
	logic [15:0] txWord;
	logic        sending;

	assign sending = state_reg == phan_pkg::ST_ABILITY ||
		state_reg == phan_pkg::ST_ACK;
	// Base word only; next-page bit stays zero
	assign txWord = {1'b0, state_reg == phan_pkg::ST_ACK,
		1'b0, 2'b00, advLatch_reg[10:5],
		`PHAN_SEL_8023};

	always_ff @(posedge ref_clk) begin
		if (sys_rst || !sending) begin
			period_reg  <= 32'h0000_0000;
			slotCnt_reg <= 11'h000;
			slot_reg    <= 6'h00;
			flpPulseOut <= 1'b0;
		end else begin
			flpPulseOut <= 1'b0;
			period_reg  <= (period_reg >= PERIOD_CYC - 1) ? 32'h0000_0000
				: period_reg + 32'h0000_0001;
			if (period_reg == 32'h0000_0000) begin
				slot_reg    <= 6'h01;
				slotCnt_reg <= 11'h000;
				flpPulseOut <= 1'b1;
			end else if (slot_reg != 6'h00) begin
				if (slotCnt_reg == 11'(SLOT_CYC - 1)) begin
					slotCnt_reg <= 11'h000;
					if (slot_reg == 6'h21) begin
						slot_reg <= 6'h00;
					end else begin
						slot_reg <= slot_reg + 6'h01;
						// Odd slots carry data, even slots frame
						flpPulseOut <= slot_reg[0] ? txWord[slot_reg[4:1]]
							: 1'b1;
					end
				end else begin
					slotCnt_reg <= slotCnt_reg + 11'h001;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Burst receiver
	// ------------------------------------------------------------------
	logic [12:0] gap_reg;
	logic [4:0]  bitIdx_reg;
	logic [15:0] shift_reg;
	logic        inBurst_reg;
	logic        rxValid_reg;
	logic [15:0] rxWord_reg;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			gap_reg     <= 13'h1fff;
			bitIdx_reg  <= 5'h00;
			shift_reg   <= 16'h0000;
			inBurst_reg <= 1'b0;
			rxValid_reg <= 1'b0;
			rxWord_reg  <= 16'h0000;
		end else begin
			rxValid_reg <= 1'b0;
			if (gap_reg != 13'h1fff)
				gap_reg <= gap_reg + 13'h0001;
			if (flpPulseIn) begin
				gap_reg <= 13'h0000;
				if (!inBurst_reg || gap_reg >= 13'(GAP_CYC)) begin
					inBurst_reg <= 1'b1;
					bitIdx_reg  <= 5'h00;
					shift_reg   <= 16'h0000;
				end else if (gap_reg < 13'(DATA_CYC)) begin
					shift_reg[bitIdx_reg[3:0]] <= 1'b1;
				end else if (bitIdx_reg == 5'h0f) begin
					inBurst_reg <= 1'b0;
					rxValid_reg <= 1'b1;
					rxWord_reg  <= shift_reg;
				end else begin
					bitIdx_reg <= bitIdx_reg + 5'h01;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Negotiation state machine
	// ------------------------------------------------------------------
	logic [2:0] res;
	assign res = resolve(advLatch_reg, rxWord_reg);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg    <= phan_pkg::ST_ABILITY;
			advLatch_reg <= `PHAN_ADV_RST;
			timer_reg    <= 32'h0000_0000;
			matchCnt_reg <= 3'h0;
			lastRx_reg   <= 16'h0000;
			rxSeen_reg   <= 1'b0;
			nlpSeen_reg  <= 1'b0;
			symSeen_reg  <= 1'b0;
			lpa_reg      <= 16'h0000;
			lpAble_reg   <= 1'b0;
			anDone_reg   <= 1'b0;
			linkMode     <= '0;
		end else if (!ctrl_reg[`PHAN_CTRL_ANEN] ||
			ctrl_reg[`PHAN_CTRL_PDOWN]) begin
			state_reg  <= phan_pkg::ST_FORCED;
			anDone_reg <= 1'b0;
			linkMode.speed100   <= ctrl_reg[`PHAN_CTRL_SPEED];
			linkMode.fullDuplex <= ctrl_reg[`PHAN_CTRL_DUPLEX];
		end else if (ctrl_reg[`PHAN_CTRL_RESTART] &&
			state_reg != phan_pkg::ST_BREAK) begin
			state_reg  <= phan_pkg::ST_BREAK;
			timer_reg  <= 32'h0000_0000;
			anDone_reg <= 1'b0;
		end else if (anTrig || state_reg == phan_pkg::ST_FORCED ||
			((state_reg == phan_pkg::ST_DONE ||
			state_reg == phan_pkg::ST_PDLINK) && !sigDetect)) begin
			// Fresh session; speed/duplex bits play no part
			state_reg    <= phan_pkg::ST_ABILITY;
			advLatch_reg <= adv_reg;
			timer_reg    <= 32'h0000_0000;
			matchCnt_reg <= 3'h0;
			rxSeen_reg   <= 1'b0;
			nlpSeen_reg  <= 1'b0;
			symSeen_reg  <= 1'b0;
			anDone_reg   <= 1'b0;
		end else begin
			case (state_reg)
				phan_pkg::ST_BREAK: begin
					timer_reg <= timer_reg + 32'h0000_0001;
					if (timer_reg >= BREAK_CYC - 1) begin
						state_reg    <= phan_pkg::ST_ABILITY;
						advLatch_reg <= adv_reg;
						timer_reg    <= 32'h0000_0000;
						matchCnt_reg <= 3'h0;
						rxSeen_reg   <= 1'b0;
						nlpSeen_reg  <= 1'b0;
						symSeen_reg  <= 1'b0;
					end
				end
				phan_pkg::ST_ABILITY: begin
					timer_reg <= timer_reg + 32'h0000_0001;
					if (nlpIn)
						nlpSeen_reg <= 1'b1;
					if (sym100In)
						symSeen_reg <= 1'b1;
					if (rxValid_reg) begin
						timer_reg  <= 32'h0000_0000;
						rxSeen_reg <= 1'b1;
						lastRx_reg <= rxWord_reg;
						if (rxWord_reg == lastRx_reg &&
							matchCnt_reg != 3'h0) begin
							matchCnt_reg <= matchCnt_reg + 3'h1;
							if (matchCnt_reg + 3'h1 >= `PHAN_MATCH_CNT &&
								res[2]) begin
								state_reg    <= phan_pkg::ST_ACK;
								lpa_reg      <= rxWord_reg;
								lpAble_reg   <= 1'b1;
								matchCnt_reg <= 3'h0;
							end
						end else begin
							matchCnt_reg <= 3'h1;
						end
					end else if (timer_reg >= MISS_CYC - 1) begin
						timer_reg    <= 32'h0000_0000;
						matchCnt_reg <= 3'h0;
						rxSeen_reg   <= 1'b0;
						nlpSeen_reg  <= 1'b0;
						symSeen_reg  <= 1'b0;
						// Parallel detect when no bursts seen and only one of link pulses or symbols
						if (!rxSeen_reg && (nlpSeen_reg ^ symSeen_reg)) begin
							state_reg  <= phan_pkg::ST_PDLINK;
							lpAble_reg <= 1'b0;
							linkMode.speed100   <= symSeen_reg;
							linkMode.fullDuplex <= 1'b0;
							lpa_reg <= 16'h0000;
							lpa_reg[`PHAN_ADV_100HD] <= symSeen_reg;
							lpa_reg[`PHAN_ADV_10HD]  <= !symSeen_reg;
						end
					end
				end
				phan_pkg::ST_ACK: begin
					timer_reg <= timer_reg + 32'h0000_0001;
					if (rxValid_reg) begin
						timer_reg <= 32'h0000_0000;
						if (rxWord_reg[12:0] != lpa_reg[12:0]) begin
							state_reg    <= phan_pkg::ST_ABILITY;
							matchCnt_reg <= 3'h0;
						end else if (rxWord_reg[`PHAN_WORD_ACK]) begin
							matchCnt_reg <= matchCnt_reg + 3'h1;
							if (matchCnt_reg + 3'h1 >= `PHAN_MATCH_CNT) begin
								state_reg  <= phan_pkg::ST_DONE;
								anDone_reg <= 1'b1;
								linkMode.speed100   <= res[1];
								linkMode.fullDuplex <= res[0];
							end
						end
					end else if (timer_reg >= MISS_CYC - 1) begin
						state_reg    <= phan_pkg::ST_ABILITY;
						timer_reg    <= 32'h0000_0000;
						matchCnt_reg <= 3'h0;
					end
				end
				phan_pkg::ST_DONE, phan_pkg::ST_PDLINK: begin
				end
				default: state_reg <= phan_pkg::ST_ABILITY;
			endcase
		end
	end

	// Fault: both line symbols and link pulses seen, no bursts; set wins
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			pdFault_reg <= 1'b0;
		else if (state_reg == phan_pkg::ST_ABILITY && !rxSeen_reg &&
			nlpSeen_reg && symSeen_reg && timer_reg >= MISS_CYC - 1)
			pdFault_reg <= 1'b1;
		else if (apbRead && addrHit == byteAddr(`PHAN_IDX_EXP))
			pdFault_reg <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Link outputs and carrier/collision
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			linkHold <= 1'b1;
			linkUp   <= 1'b0;
			crs      <= 1'b0;
			col      <= 1'b0;
		end else begin
			// Traffic halts while negotiating or during break
			linkHold <= ctrl_reg[`PHAN_CTRL_PDOWN] ||
				(state_reg != phan_pkg::ST_DONE &&
				state_reg != phan_pkg::ST_PDLINK &&
				state_reg != phan_pkg::ST_FORCED);
			linkUp <= sigDetect && !ctrl_reg[`PHAN_CTRL_PDOWN] &&
				(state_reg == phan_pkg::ST_DONE ||
				state_reg == phan_pkg::ST_PDLINK ||
				state_reg == phan_pkg::ST_FORCED);
			if (linkMode.fullDuplex) begin
				crs <= rxActive;
				col <= 1'b0;
			end else begin
				crs <= rxActive || txActive;
				col <= rxActive && txActive;
			end
		end
	end

endmodule : phan_autoneg

// file: pkg/phan_defines.svh
// Purpose: Offsets, field positions, reset values and timings, negotiation
// Assumes: 20 MHz reference clock, APB byte addresses = 4 x register index
// Notes:   Times are given in ns or ms; cycle counts derive from them
`ifndef PHAN_DEFINES_SVH
`define PHAN_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices; byte addresses are formed in byteAddr
// ----------------------------------------------------------------------
`define PHAN_IDX_CTRL      5'd0
`define PHAN_IDX_ADV       5'd4
`define PHAN_IDX_LPA       5'd5
`define PHAN_IDX_EXP       5'd6
`define PHAN_IDX_SPEC      5'd31

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PHAN_CTRL_SRST     15
`define PHAN_CTRL_SPEED    13
`define PHAN_CTRL_ANEN     12
`define PHAN_CTRL_PDOWN    11
`define PHAN_CTRL_RESTART  9
`define PHAN_CTRL_DUPLEX   8
`define PHAN_ADV_10HD      5
`define PHAN_ADV_100HD     7
`define PHAN_WORD_ACK      14
`define PHAN_EXP_LPANABLE  0
`define PHAN_EXP_PDFAULT   4
`define PHAN_SPEC_DONE     12
`define PHAN_SPEC_IND_LO   2
`define PHAN_SEL_8023      5'h01
`define PHAN_SEL_W         5

// ----------------------------------------------------------------------
// Reset values and speed indication codes
// ----------------------------------------------------------------------
`define PHAN_CTRL_RST      16'h3100
`define PHAN_ADV_RST       16'h01e1
`define PHAN_SPEC_10HD     3'h1
`define PHAN_SPEC_10FD     3'h5
`define PHAN_SPEC_100HD    3'h2
`define PHAN_SPEC_100FD    3'h6

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PHAN_CLK_NS        50
`define PHAN_SLOT_NS       62500
`define PHAN_DATA_MAX_NS   94000
`define PHAN_GAP_NS        200000
`define PHAN_PERIOD_NS     16000000
`define PHAN_MISS_NS       50000000
`define PHAN_BREAK_MS      1200
`define PHAN_MATCH_CNT     3'd3

`endif

// file: pkg/phan_pkg.sv
// Purpose: Types shared by the negotiation logic
// Assumes: Nothing beyond plain SystemVerilog
// Notes:   Constants live in phan_defines.svh
package phan_pkg;

	typedef enum logic [2:0] {
		ST_FORCED  = 3'b000,
		ST_BREAK   = 3'b001,
		ST_ABILITY = 3'b010,
		ST_ACK     = 3'b011,
		ST_DONE    = 3'b100,
		ST_PDLINK  = 3'b101
	} phan_state_t;

	typedef struct packed {
		logic speed100;
		logic fullDuplex;
	} phan_mode_t;

endpackage : phan_pkg

// file: bench/phan_autoneg_assertions.sv
// Purpose: Port-level checks for the negotiation block
// Assumes: One clock domain, sys_rst synchronous active high
// Notes:   Carrier checks only while link is up and traffic allowed
`timescale 1ns/100ps
module phan_autoneg_assertions (
	input wire logic                 ref_clk,
	input wire logic                 sys_rst,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [7:0]           paddr,
	input wire logic [31:0]          pwdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic                 txActive,
	input wire logic                 rxActive,
	input wire logic                 flpPulseOut,
	input wire logic                 linkHold,
	input wire logic                 linkUp,
	input wire logic                 crs_q,
	input wire logic                 col_q,
	input wire phan_pkg::phan_mode_t linkMode
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// ------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_quiet;
		!flpPulseOut [*8];
	endsequence
	sequence s_steady;
		linkUp && !linkHold && $stable(linkMode);
	endsequence
	sequence s_restart_wr;
		psel && penable && pready && pwrite && paddr == 8'h00
			&& pwdata[12] && pwdata[9];
	endsequence

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	a_apb_answer: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_flp_spacing: assert property (flpPulseOut |=> s_quiet)
		else $error("link pulses too close");
	a_hd_collide: assert property (linkUp && !linkHold
		&& !linkMode.fullDuplex && txActive && rxActive ##1 s_steady
		|-> col_q) else $error("no collision in half duplex");
	a_fd_nocol: assert property (linkMode.fullDuplex
		##1 $stable(linkMode) |-> !col_q)
		else $error("collision in full duplex");
	a_rx_carrier: assert property (linkUp && !linkHold && rxActive
		##1 s_steady |-> crs_q) else $error("no carrier on receive");
	a_fd_txonly: assert property (linkUp && !linkHold
		&& linkMode.fullDuplex && txActive && !rxActive ##1 s_steady
		|-> !crs_q) else $error("carrier on transmit in full duplex");
	a_hd_txcrs: assert property (linkUp && !linkHold
		&& !linkMode.fullDuplex && txActive ##1 s_steady
		|-> crs_q) else $error("no carrier on transmit in half duplex");
	a_restart_hold: assert property (s_restart_wr
		|-> ##[1:3] linkHold [*8]) else $error("traffic not stopped");
endmodule : phan_autoneg_assertions

// file: bench/phan_link_partner.sv
// Purpose: Remote partner that cannot negotiate
// Assumes: Mode 0 silent, bit0 link pulses, bit1 100M symbols
// Notes:   Sends no bursts, so only parallel detection or forced mode can link
`timescale 1ns/100ps
module phan_link_partner #(
	parameter int NLP_GAP = 2000
) (
	input  wire logic       ref_clk,
	input  wire logic [1:0] lpMode,
	output logic            flpPulseIn,
	output logic            nlpIn,
	output logic            sym100In,
	output logic            sigDetect
);
	int gapCnt = 0;

	// Legacy partner: no burst pulses are ever sent
	assign flpPulseIn = 1'b0;
	always_ff @(posedge ref_clk) begin
		gapCnt    <= (gapCnt >= NLP_GAP - 1) ? 0 : gapCnt + 1;
		nlpIn     <= lpMode[0] && gapCnt == 0;
		sym100In  <= lpMode[1];
		sigDetect <= |lpMode;
	end
endmodule : phan_link_partner

// file: bench/phan_autoneg_tb.sv
// Purpose: Self-checking bench for the negotiation block
// Assumes: Shortened timers; partner only does parallel detection
// Notes:   Full burst exchange would exceed the run length budget
`timescale 1ns/100ps
`include "phan_defines.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
	n_errors++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
	end end
module phan_autoneg_tb;
	localparam logic [15:0] ADV0 = `PHAN_ADV_RST;
	localparam int LIMIT = 90000;
	logic ref_clk, sys_rst, psel, penable, pwrite, flpPulseIn, nlpIn;
	logic sym100In, sigDetect, txActive, rxActive, flpPulseOut, linkHold;
	logic linkUp, crs, col, pready, pslverr, burstDone;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0]  lpMode;
	logic [15:0] rnd;
	logic [32:0] note;
	logic [32:0] expQ[$];
	phan_pkg::phan_mode_t linkMode;
	int n_errors, cmp_count, cyc;

	phan_autoneg #(.PERIOD_CYC(42000), .MISS_CYC(60000), .BREAK_CYC(100))
	phan_autoneg_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flpPulseIn(flpPulseIn), .nlpIn(nlpIn), .sym100In(sym100In),
		.sigDetect(sigDetect), .txActive(txActive), .rxActive(rxActive),
		.flpPulseOut(flpPulseOut), .linkHold(linkHold), .linkUp(linkUp),
		.linkMode(linkMode), .crs(crs), .col(col));
	phan_link_partner phan_link_partner_i (.ref_clk(ref_clk),
		.lpMode(lpMode), .flpPulseIn(flpPulseIn), .nlpIn(nlpIn),
		.sym100In(sym100In), .sigDetect(sigDetect));

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	// ------------------------------------------------------------
	// APB master
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [4:0] idx,
		input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {1'b0, idx, 2'b00};
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		psel    <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following call never drives psel twice at once
		@(posedge ref_clk);
	endtask : apb

	task automatic apb_rd(input logic [4:0] idx, input logic err,
		input logic [31:0] ex);
		expQ.push_back({err, ex});
		apb(1'b0, idx, 32'h0000_0000);
	endtask : apb_rd

	// ------------------------------------------------------------
	// Clock, traffic, timeout and read monitor
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// Random activity keeps the carrier checks busy in both duplex modes
	always @(posedge ref_clk) begin
		rnd      <= lfsr_next(rnd);
		txActive <= rnd[0];
		rxActive <= rnd[3];
		cyc      <= cyc + 1;
		if (cyc == LIMIT) begin
			n_errors++;
			final_report();
		end
	end
	always @(posedge ref_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			note = (expQ.size() > 0) ? expQ.pop_front() : 33'h1_dead_beef;
			`CHK("readData", note, {pslverr, prdata})
		end
	end

	// ------------------------------------------------------------
	// First transmitted burst, decoded by pulse spacing
	// ------------------------------------------------------------
	initial begin : capture
		int nClk, tick, lastClk, first;
		logic [15:0] word;
		nClk = 0; tick = 0; lastClk = 0; first = 0; word = 16'h0000;
		burstDone = 1'b0;
		@(negedge sys_rst);
		while (nClk < 17) begin
			@(posedge ref_clk);
			tick++;
			if (flpPulseOut === 1'b1) begin
				if (nClk > 0 && tick - lastClk < 1880)
					word[nClk - 1] = 1'b1;
				else begin
					if (nClk == 0)
						first = tick;
					nClk++;
					lastClk = tick;
				end
			end
		end
		`CHK("burstSpan", 40000, lastClk - first)
		`CHK("burstWord", {3'b000, ADV0[12:5], `PHAN_SEL_8023}, word)
		$display("test burst done");
		burstDone = 1'b1;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0000_0000; lpMode = 2'b01;
		rnd = 16'h0015; cyc = 0; n_errors = 0; cmp_count = 0;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		apb_rd(5'd0, 1'b0, {16'h0000, `PHAN_CTRL_RST});
		apb_rd(5'd4, 1'b0, {16'h0000, ADV0});
		apb_rd(5'd2, 1'b1, 32'h0000_0000);
		apb(1'b1, 5'd4, 32'h0000_0000);
		apb_rd(5'd4, 1'b0, {16'h0000, ADV0 & 16'hfe1f});
		apb(1'b1, 5'd4, {16'h0000, ADV0});
		$display("test registers done");
		wait (burstDone === 1'b1);
		while (linkUp !== 1'b1) @(posedge ref_clk);
		@(posedge ref_clk);
		`CHK("pdMode", 2'b00, linkMode)
		apb_rd(5'd6, 1'b0, 32'h0000_0000);
		apb_rd(5'd5, 1'b0, 32'h0000_0020);
		apb_rd(5'd31, 1'b0, 32'h0000_0004);
		$display("test parallel detect done");
		lpMode <= 2'b00;
		for (int i = 0; i < 2000 && linkUp === 1'b1; i++) @(posedge ref_clk);
		`CHK("lossLink", 1'b0, linkUp)
		lpMode <= 2'b01;
		$display("test signal loss done");
		apb(1'b1, 5'd0, 32'h0000_2100);
		for (int i = 0; i < 50 && linkMode !== 2'b11; i++) @(posedge ref_clk);
		`CHK("forcedFast", 2'b11, linkMode)
		repeat (200) @(posedge ref_clk);
		apb(1'b1, 5'd0, 32'h0000_0000);
		for (int i = 0; i < 50 && linkMode !== 2'b00; i++) @(posedge ref_clk);
		`CHK("forcedSlow", 2'b00, linkMode)
		repeat (200) @(posedge ref_clk);
		$display("test forced mode done");
		apb(1'b1, 5'd0, 32'h0000_3300);
		@(posedge ref_clk);
		apb_rd(5'd0, 1'b0, 32'h0000_3100);
		`CHK("holdTraffic", 1'b1, linkHold)
		repeat (20) @(posedge ref_clk);
		$display("test restart done");
		apb(1'b1, 5'd4, 32'h0000_0000);
		apb(1'b1, 5'd0, 32'h0000_8000);
		apb_rd(5'd0, 1'b0, {16'h0000, `PHAN_CTRL_RST});
		apb_rd(5'd4, 1'b0, {16'h0000, ADV0});
		$display("test soft reset done");
		final_report();
	end
endmodule : phan_autoneg_tb

bind phan_autoneg phan_autoneg_assertions phan_autoneg_assertions_i (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .txActive(txActive), .rxActive(rxActive),
	.flpPulseOut(flpPulseOut), .linkHold(linkHold), .linkUp(linkUp),
	.linkMode(linkMode), .crs_q(crs), .col_q(col));
